// >>> core/pce_pkg.sv
// Summary of operation
// - Separate disables for engine and scanner
// - Scanner disable honoured only when scanner available
// - Enable bit releases engine from reset
// - Start bit runs shifter, clear stops it
// - Busy reads 1 while shifting or pending
// - Mode bit selects zero augmentation
// - Direction bit: right LSB first, left MSB first
// - Full flag set until word enters shifter
// - Data length field is bits per word minus one
// - Polynomial length field sets accumulator width
// - Sixteen-bit data register, input and output path
// - Accumulator byte writes preset the seed
// - Accumulator reads back, clears on reset
// - Shifter view is read-only shifter contents
// - Polynomial bits enable feedback taps
// - Polynomial bit zero always reads one
package pce_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 4;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_DATA = 12'hf6f;
  localparam logic [11:0] IDX_ACC = 12'hf71;
  localparam logic [11:0] IDX_SHIFT = 12'hf73;
  localparam logic [11:0] IDX_POLY = 12'hf75;
  localparam logic [11:0] IDX_CTRL = 12'hf77;
  localparam logic [11:0] IDX_LEN = 12'hf78;
  localparam logic [11:0] IDX_PMD = 12'hf7a;
  // Control register fields
  localparam int CTRL_EN = 7;
  localparam int CTRL_GO = 6;
  localparam int CTRL_BUSY = 5;
  localparam int CTRL_ZERO_AUGMENT_MODE = 4;
  localparam int CTRL_SHIFT_DIRECTION = 1;
  localparam int CTRL_FULL = 0;
  // Length register fields
  localparam int LEN_DATA_LENGTH_MINUS_ONE_LSB = 4;
  localparam int LEN_POLY_LENGTH_MINUS_ONE_LSB = 0;
  // Module disable register fields
  localparam int PMD_CRC = 0;
  localparam int PMD_SCAN = 1;
  // Reset values and mask constants
  localparam logic [7:0] LEN_RESET = 8'h00;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  localparam logic [15:0] POLY_RESET = 16'h0001;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [3:0] MAX_IDX = 4'hf;
  typedef enum logic [0:0] {
    PCE_IDLE = 1'b0,
    PCE_SHIFT = 1'b1
  } pce_eng_t;
endpackage

// >>> core/pce_crc_engine.sv
// Added by the designer: the data word FIFO.
module pce_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [PW:0] count;
  } pce_fifo_st_t;
  pce_fifo_st_t s;
  pce_fifo_st_t next_s;
  logic push;
  logic pop;
  assign inReady = s.count != (PW+1)'(DEPTH);
  assign outValid = s.count != '0;
  assign outData = s.mem[s.rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = (s.wrPtr == PW'(DEPTH - 1)) ? '0 : s.wrPtr + 1'b1;
    end
    if (pop)
    begin
      next_s.rdPtr = (s.rdPtr == PW'(DEPTH - 1)) ? '0 : s.rdPtr + 1'b1;
    end
    next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule

module pce_crc_engine
  import pce_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scannerAvailableCfg,
  output logic crcModuleActive,
  output logic scannerModuleActive
);
  typedef struct packed {
    pce_eng_t state;
    logic en;
    logic go;
    logic zero_augment_mode;
    logic shift_direction;
    logic [7:0] lenCfg;
    logic [15:1] poly;
    logic [15:0] acc;
    logic [15:0] dataHold;
    logic full;
    logic [15:0] shifter;
    logic [4:0] bitsLeft;
    logic crc_module_disable;
    logic scanner_module_disable;
    logic cfgMeta;
    logic cfgSync;
    logic crcActive;
    logic scanActive;
    logic [31:0] rdata;
    logic err;
  } pce_state_t;
  pce_state_t s;
  pce_state_t next_s;
  logic engineRun;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic fifoFlush;
  logic [15:0] fifoData;
  logic dataPush;
  logic [11:0] idx;
  logic hit;
  logic setup;
  logic access;
  logic busy;
  logic [3:0] data_length_minus_one;
  logic [3:0] poly_length_minus_one;
  logic [15:0] polyFull;
  logic [15:0] revPoly;
  logic [15:0] mask;
  logic dbit;
  logic fb;
  logic [15:0] shifted;
  logic stepping;

  assign idx = paddr[13:2];
  assign hit = (paddr[ADDR_W-1:14] == '0) && (paddr[1:0] == 2'b00) &&
               (idx == IDX_DATA || idx == IDX_ACC || idx == IDX_SHIFT ||
                idx == IDX_POLY || idx == IDX_CTRL || idx == IDX_LEN || idx == IDX_PMD);
  assign setup = psel & ~penable;
  assign data_length_minus_one = s.lenCfg[LEN_DATA_LENGTH_MINUS_ONE_LSB+3:LEN_DATA_LENGTH_MINUS_ONE_LSB];
  assign poly_length_minus_one = s.lenCfg[LEN_POLY_LENGTH_MINUS_ONE_LSB+3:LEN_POLY_LENGTH_MINUS_ONE_LSB];
  assign polyFull = {s.poly, 1'b1};
  assign mask = ALL_ONES >> (MAX_IDX - poly_length_minus_one);
  assign engineRun = s.en & ~s.crc_module_disable;
  assign busy = (s.state == PCE_SHIFT) | s.full | fifoOutValid;
  assign stepping = engineRun & (s.state == PCE_SHIFT) & s.go;
  // Writes to the data word stall while the FIFO is full
  assign dataPush = psel & penable & pwrite & hit & (idx == IDX_DATA);
  assign pready = ~(dataPush & ~fifoInReady);
  assign access = psel & penable & pready;
  assign fifoPop = engineRun & ~s.full;
  assign fifoFlush = sys_rst | ~engineRun;
  assign prdata = s.rdata;
  assign pslverr = s.err;
  assign crcModuleActive = s.crcActive;
  assign scannerModuleActive = s.scanActive;

  pce_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(fifoFlush),
    .inValid(dataPush & ~s.err),
    .inReady(fifoInReady),
    .inData(pwdata[15:0]),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // Reflected taps for right shifting
  always_comb
  begin
    revPoly = '0;
    for (int i = 0; i < 16; i++)
    begin
      if (4'(i) <= poly_length_minus_one)
      begin
        revPoly[i] = polyFull[4'(poly_length_minus_one - 4'(i))];
      end
    end
  end

  // One accumulation step
  always_comb
  begin
    dbit = s.shift_direction ? s.shifter[0] : s.shifter[data_length_minus_one];
    if (s.shift_direction)
    begin
      fb = s.zero_augment_mode ? s.acc[0] : (s.acc[0] ^ dbit);
      shifted = s.acc >> 1;
      shifted[poly_length_minus_one] = s.zero_augment_mode & dbit;
      shifted = shifted ^ (fb ? revPoly : '0);
    end
    else
    begin
      fb = s.zero_augment_mode ? s.acc[poly_length_minus_one] : (s.acc[poly_length_minus_one] ^ dbit);
      shifted = {s.acc[14:0], s.zero_augment_mode & dbit};
      shifted = shifted ^ (fb ? polyFull : '0);
    end
    shifted = shifted & mask;
  end

  always_comb
  begin
    next_s = s;
    next_s.cfgMeta = scannerAvailableCfg;
    next_s.cfgSync = s.cfgMeta;
    next_s.crcActive = engineRun;
    next_s.scanActive = s.cfgSync & ~s.scanner_module_disable;
    if (!engineRun)
    begin
      next_s.state = PCE_IDLE;
      next_s.full = 1'b0;
      next_s.shifter = '0;
      next_s.bitsLeft = '0;
    end
    else
    begin
      if (fifoPop && fifoOutValid)
      begin
        next_s.full = 1'b1;
        next_s.dataHold = fifoData;
      end
      case (s.state)
        PCE_IDLE:
        begin
          if (s.go && s.full)
          begin
            next_s.shifter = s.dataHold;
            next_s.full = 1'b0;
            next_s.bitsLeft = 5'(data_length_minus_one) + 5'd1;
            next_s.state = PCE_SHIFT;
          end
        end
        PCE_SHIFT:
        begin
          if (s.go)
          begin
            next_s.acc = shifted;
            next_s.shifter = s.shift_direction ? (s.shifter >> 1) : (s.shifter << 1);
            next_s.bitsLeft = s.bitsLeft - 5'd1;
            if (s.bitsLeft == 5'd1)
            begin
              next_s.state = PCE_IDLE;
            end
          end
        end
        default:
        begin
          next_s.state = PCE_IDLE;
        end
      endcase
    end
    if (setup)
    begin
      next_s.err = ~hit;
      next_s.rdata = '0;
      case (idx)
        IDX_DATA: next_s.rdata[15:0] = s.dataHold;
        IDX_ACC: next_s.rdata[15:0] = s.acc;
        IDX_SHIFT: next_s.rdata[15:0] = s.shifter;
        IDX_POLY: next_s.rdata[15:0] = polyFull;
        IDX_CTRL:
        begin
          next_s.rdata[CTRL_EN] = s.en;
          next_s.rdata[CTRL_GO] = s.go;
          next_s.rdata[CTRL_BUSY] = busy;
          next_s.rdata[CTRL_ZERO_AUGMENT_MODE] = s.zero_augment_mode;
          next_s.rdata[CTRL_SHIFT_DIRECTION] = s.shift_direction;
          next_s.rdata[CTRL_FULL] = s.full;
        end
        IDX_LEN: next_s.rdata[7:0] = s.lenCfg;
        IDX_PMD:
        begin
          next_s.rdata[PMD_CRC] = s.crc_module_disable;
          next_s.rdata[PMD_SCAN] = s.scanner_module_disable;
        end
        default: next_s.rdata = '0;
      endcase
      if (!hit)
      begin
        next_s.rdata = '0;
      end
    end
    if (access && pwrite && !s.err)
    begin
      case (idx)
        IDX_ACC:
        begin
          if (pstrb[0])
          begin
            next_s.acc[7:0] = pwdata[7:0];
          end
          if (pstrb[1])
          begin
            next_s.acc[15:8] = pwdata[15:8];
          end
        end
        IDX_POLY:
        begin
          if (pstrb[0])
          begin
            next_s.poly[7:1] = pwdata[7:1];
          end
          if (pstrb[1])
          begin
            next_s.poly[15:8] = pwdata[15:8];
          end
        end
        IDX_CTRL:
        begin
          if (pstrb[0])
          begin
            next_s.en = pwdata[CTRL_EN];
            next_s.go = pwdata[CTRL_GO];
            next_s.zero_augment_mode = pwdata[CTRL_ZERO_AUGMENT_MODE];
            next_s.shift_direction = pwdata[CTRL_SHIFT_DIRECTION];
          end
        end
        IDX_LEN:
        begin
          if (pstrb[0])
          begin
            next_s.lenCfg = pwdata[7:0];
          end
        end
        IDX_PMD:
        begin
          if (pstrb[0])
          begin
            next_s.crc_module_disable = pwdata[PMD_CRC];
            next_s.scanner_module_disable = pwdata[PMD_SCAN];
          end
        end
        default:
        begin
          next_s.err = s.err;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.state <= PCE_IDLE;
      s.lenCfg <= LEN_RESET;
      s.poly <= POLY_RESET[15:1];
      s.acc <= ACC_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence seqLoad;
    engineRun && s.state == PCE_IDLE && s.go && s.full;
  endsequence
  sequence seqShifting;
    s.state == PCE_SHIFT && !s.full;
  endsequence

  AST_DISABLE_HOLDS: assert property (!engineRun |=> s.state == PCE_IDLE && !s.full)
    else $error("Disabled engine not held in reset");
  AST_MD_STOPS: assert property (s.crc_module_disable |=> !crcModuleActive && s.bitsLeft == '0)
    else $error("Module disable did not stop engine");
  AST_SCAN_CFG: assert property (!s.cfgSync |=> !scannerModuleActive)
    else $error("Scanner active while unavailable");
  AST_LOAD: assert property (seqLoad |=> seqShifting ##0 s.bitsLeft == 5'($past(data_length_minus_one)) + 5'd1)
    else $error("Word load into shifter wrong");
  AST_PAUSE: assert property (engineRun && s.state == PCE_SHIFT && !s.go |=> $stable(s.shifter))
    else $error("Shifter moved while start clear");
  AST_COUNT: assert property (stepping |=> s.bitsLeft == $past(s.bitsLeft) - 5'd1)
    else $error("Bit count did not step");
  AST_BUSY: assert property (seqLoad |=> busy [*1] ##1 (busy || !s.go))
    else $error("Busy dropped while shifting");
  AST_WIDTH: assert property (stepping && !(access && pwrite) |=> (s.acc & ~mask) == '0)
    else $error("Accumulator exceeds polynomial width");
  AST_POLY_BIT0: assert property (setup && hit && idx == IDX_POLY |=> prdata[0])
    else $error("Constant term bit read as zero");
  AST_SEED: assert property (access && pwrite && !s.err && idx == IDX_ACC && pstrb[1:0] == 2'b11
    |=> s.acc == $past(pwdata[15:0]))
    else $error("Accumulator seed not loaded");
endmodule

// >>> tb/pce_crc_engine_tb.sv
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module pce_crc_engine_tb
  import pce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scannerAvailableCfg = 1'b0;
  logic crcModuleActive;
  logic scannerModuleActive;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  logic [15:0] ex;
  logic [7:0] cb;
  logic [15:0] sv;
  logic [7:0] lens [4] = '{8'h77, 8'h3c, 8'hf4, 8'hff};
  logic [15:0] polys [4] = '{16'h0007, 16'h1021, 16'h0015, 16'h8005};
  logic [15:0] seeds [4] = '{16'h0000, 16'h1fff, 16'h001f, 16'hffff};

  pce_crc_engine i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scannerAvailableCfg(scannerAvailableCfg),
    .crcModuleActive(crcModuleActive), .scannerModuleActive(scannerModuleActive));

  always #10 clk = ~clk;

  function automatic logic [15:0] A(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [15:0] wd(input int i);
    return 16'h3c5a ^ (16'h1357 * i[15:0]);
  endfunction

  // Reference CRC step model over one word
  function automatic logic [15:0] crcm(input logic [15:0] a, input logic [15:0] w,
    input int p, input int d, input logic [15:0] q, input logic r, input logic g);
    logic [15:0] m;
    logic [15:0] rq;
    logic b;
    logic f;
    m = 16'hffff >> (15 - p);
    q = q | 16'h0001;
    rq = 16'h0000;
    for (int i = 0; i <= p; i++) rq[p-i] = q[i];
    for (int i = 0; i <= d; i++)
    begin
      b = r ? w[i] : w[d-i];
      if (!r)
      begin
        f = a[p] ^ (g ? 1'b0 : b);
        a = (a << 1) | {15'h0, g & b};
        if (f) a = a ^ q;
      end
      else
      begin
        f = a[0] ^ (g ? 1'b0 : b);
        a = (a >> 1) | ({15'h0, g & b} << p);
        if (f) a = a ^ rq;
      end
      a = a & m;
    end
    return a;
  endfunction

  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
    input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude();
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, A(IDX_CTRL), 0, 0); `CHK(rd[7:0], 8'h00)
    bus(0, A(IDX_LEN), 0, 0); `CHK(rd[7:0], 8'h00)
    bus(0, A(IDX_ACC), 0, 0); `CHK(rd[15:0], 16'h0000)
    bus(1, A(IDX_SHIFT), 16'h5555, 4'hf);
    bus(0, A(IDX_SHIFT), 0, 0); `CHK(rd[15:0], 16'h0000)
    bus(1, A(IDX_POLY), 16'h0000, 4'hf);
    bus(0, A(IDX_POLY), 0, 0); `CHK(rd[15:0], 16'h0001)
    bus(1, A(IDX_POLY), 16'hffff, 4'h2);
    bus(0, A(IDX_POLY), 0, 0); `CHK(rd[15:0], 16'hff01)
    bus(1, A(IDX_ACC), 16'h1234, 4'hf);
    bus(1, A(IDX_ACC), 16'habcd, 4'h1);
    bus(0, A(IDX_ACC), 0, 0); `CHK(rd[15:0], 16'h12cd)
    bus(0, A(12'h100), 0, 0); `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    bus(0, A(IDX_ACC) | 16'h0001, 0, 0); `CHK(er, 1'b1)
    bus(1, A(IDX_DATA), 16'hbeef, 4'hf);
    bus(0, A(IDX_CTRL), 0, 0); `CHK(rd[7:0], 8'h00)
    `CHK(crcModuleActive, 1'b0)
    bus(1, A(IDX_CTRL), 16'h0080, 4'h1);
    for (int j = 0; j < 8; j++)
    begin
      scannerAvailableCfg <= j[2];
      bus(1, A(IDX_PMD), {14'h0, j[1:0]}, 4'h1);
      repeat (6) @(posedge clk);
      `CHK(crcModuleActive, !j[0])
      `CHK(scannerModuleActive, j[2] & !j[1])
    end
    bus(1, A(IDX_PMD), 16'h0000, 4'h1);
    for (int k = 0; k < 4; k++)
    begin
      cb = 8'h80 | {3'b000, k[1], 2'b00, k[0], 1'b0};
      bus(1, A(IDX_CTRL), 16'h0000, 4'h1);
      bus(1, A(IDX_LEN), {8'h00, lens[k]}, 4'h1);
      bus(1, A(IDX_POLY), polys[k], 4'h3);
      bus(1, A(IDX_ACC), seeds[k], 4'h3);
      bus(1, A(IDX_CTRL), {8'h00, cb}, 4'h1);
      ex = seeds[k];
      for (int i = 0; i < k + 2; i++)
      begin
        bus(1, A(IDX_DATA), wd(i), 4'h3);
        ex = crcm(ex, wd(i), lens[k][3:0], lens[k][7:4], polys[k], k[0], k[1]);
      end
      bus(0, A(IDX_CTRL), 0, 0); `CHK(rd[7:0], cb | 8'h21)
      bus(0, A(IDX_DATA), 0, 0); `CHK(rd[15:0], wd(0))
      bus(1, A(IDX_CTRL), {8'h00, cb | 8'h40}, 4'h1);
      bus(1, A(IDX_CTRL), {8'h00, cb}, 4'h1);
      bus(0, A(IDX_SHIFT), 0, 0);
      sv = rd[15:0];
      bus(0, A(IDX_CTRL), 0, 0); `CHK(rd[7:0] & 8'hfe, cb | 8'h20)
      bus(0, A(IDX_SHIFT), 0, 0); `CHK(rd[15:0], sv)
      bus(1, A(IDX_CTRL), {8'h00, cb | 8'h40}, 4'h1);
      repeat (100)
      begin
        bus(0, A(IDX_CTRL), 0, 0);
        if (rd[5] === 1'b0) break;
      end
      `CHK(rd[7:0], cb | 8'h40)
      bus(0, A(IDX_ACC), 0, 0); `CHK(rd[15:0], ex)
      sv = k[0] ? wd(k + 1) >> (lens[k][7:4] + 1) : wd(k + 1) << (lens[k][7:4] + 1);
      bus(0, A(IDX_SHIFT), 0, 0); `CHK(rd[15:0], sv)
    end
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, A(IDX_ACC), 0, 0); `CHK(rd[15:0], 16'h0000)
    bus(0, A(IDX_CTRL), 0, 0); `CHK(rd[7:0], 8'h00)
    bus(0, A(IDX_POLY), 0, 0); `CHK(rd[15:0], 16'h0001)
    conclude();
  end
endmodule
